// ### fupc_cfg.svh
// Constants of the flash user-programming controller
`ifndef FUPC_CFG_SVH
`define FUPC_CFG_SVH
`define FUPC_KEY 8'ha5
`define FUPC_CMD_ERASE 4'ha
`define FUPC_CMD_PROG 4'h5
`define FUPC_CMD_LOCK 4'h6
`define FUPC_START_BIT 0
`define FUPC_STAT_BIT 3
`define FUPC_MODE_HI 7
`define FUPC_MODE_LO 4
`define FUPC_A_CTRL 5'h00
`define FUPC_A_KEY 5'h04
`define FUPC_A_SECH 5'h08
`define FUPC_A_SECL 5'h0c
`define FUPC_A_INFO 5'h10
`define FUPC_SECL_MSB 7
`define FUPC_BOOT_BASE 16'h0100
`define FUPC_BOOT_MIN 16'h0100
`define FUPC_OPT_BOOT_OFF 2
`define FUPC_OPT_VEC_OFF 7
`define FUPC_VEC_NONE 16'h0100
`define FUPC_VEC_0 16'h0200
`define FUPC_VEC_1 16'h0300
`define FUPC_VEC_2 16'h0500
`define FUPC_VEC_3 16'h0900
`define FUPC_ERASE_MS 10
`define FUPC_CLK_HZ 50000000
`define FUPC_ERASE_CYC ((`FUPC_ERASE_MS * `FUPC_CLK_HZ + 999) / 1000)
`define FUPC_PROG_CYC 8
`define FUPC_LOCK_CYC 8
`define FUPC_CNT_W 20
`endif

// ### fupc_flash_ctrl.sv
// Flash user-programming controller with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "fupc_cfg.svh"

module fupc_flash_ctrl #(
	parameter int ERASE_CYC = `FUPC_ERASE_CYC,
	parameter int PROG_CYC = `FUPC_PROG_CYC,
	parameter int LOCK_CYC = `FUPC_LOCK_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:0] pm_addr,
	input wire logic pm_load,
	input wire logic pm_store,
	input wire logic [7:0] pm_wdata,
	output logic [7:0] pm_rdata,
	output logic pm_rvalid,
	output logic pm_refused,
	output logic pm_busy,
	input wire logic irq_pending,
	input wire logic subsys_clk,
	input wire logic tool_mode,
	input wire logic tool_rdprot_set,
	input wire logic [7:0] option_bits,
	output logic [15:0] reset_vector,
	output logic read_protect,
	output logic erase_irq_bypass,
	output logic fl_erase,
	output logic fl_prog,
	output logic fl_lock,
	output logic fl_read,
	output logic [15:0] fl_addr,
	output logic [15:0] fl_raddr,
	output logic [7:0] fl_wdata,
	input wire logic [7:0] fl_rdata,
	input wire logic fl_fail
);

	fupc_pkg::fupc_state_t state_r;
	logic [`FUPC_CNT_W-1:0] cnt_r;
	logic [7:0] key_r;
	logic [3:0] mode_r;
	logic stat_r;
	logic [7:0] sech_r;
	logic [7:0] secl_r;
	logic locked_r;
	logic [7:0] opt_r;
	logic opt_ok_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic rd_pend_r;
	logic [7:0] pm_rdata_r;
	logic pm_rvalid_r;
	logic pm_refused_r;
	logic [15:0] vec_r;
	logic rdprot_r;
	logic fl_erase_r;
	logic fl_prog_r;
	logic fl_lock_r;
	logic fl_read_r;
	logic [15:0] fl_addr_r;
	logic [15:0] fl_raddr_r;
	logic [7:0] fl_wdata_r;
	logic busy_r;

	logic key_ok;
	logic usr_ok;
	logic wr_acc;
	logic start;
	logic boot_en;
	logic [15:0] boot_end;
	logic [15:0] sec_base;
	logic sec_prot;
	logic st_prot;
	logic st_ok;
	logic idle;
	logic [3:0] cmd_w;

	assign key_ok = key_r == `FUPC_KEY;
	assign usr_ok = key_ok && !irq_pending && !subsys_clk;
	assign wr_acc = avs_write && !wait_r && avs_byteenable[0];
	assign idle = state_r == fupc_pkg::FUPC_IDLE;

	// Launch only by a keyed control write with bit 0 set
	assign start = wr_acc && avs_address == `FUPC_A_CTRL && usr_ok
		&& avs_writedata[`FUPC_START_BIT];

	// Command of the launching write itself, not the stored mode
	assign cmd_w = avs_writedata[`FUPC_MODE_HI:`FUPC_MODE_LO];

	// Boot region active while its option bit is low
	assign boot_en = !opt_r[`FUPC_OPT_BOOT_OFF];
	assign boot_end = `FUPC_BOOT_BASE + (`FUPC_BOOT_MIN << opt_r[1:0]);

	// Sector base from high byte and bit 7 of low byte
	assign sec_base = {sech_r, secl_r[`FUPC_SECL_MSB], 7'h00};

	// Region edges are 256-byte multiples, so the base decides
	assign sec_prot = boot_en && !tool_mode && sec_base >= `FUPC_BOOT_BASE
		&& sec_base < boot_end;
	assign st_prot = boot_en && !tool_mode && pm_addr >= `FUPC_BOOT_BASE
		&& pm_addr < boot_end;

	// Store programs only when keyed, armed and idle
	assign st_ok = idle && usr_ok && mode_r == `FUPC_CMD_PROG
		&& !st_prot && !locked_r;

	// Avalon handshake: one wait cycle, then one ready cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wait_r <= 1'b1;
		end else if ((avs_read || avs_write) && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	// Read data captured during the wait cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read && wait_r) begin
			unique case (avs_address)
				`FUPC_A_CTRL: begin
					rdata_r <= {24'h00_0000, mode_r, stat_r, 2'b00, !idle};
				end
				`FUPC_A_KEY: begin
					rdata_r <= {24'h00_0000, key_r};
				end
				`FUPC_A_SECH: begin
					rdata_r <= {24'h00_0000, sech_r};
				end
				`FUPC_A_SECL: begin
					rdata_r <= {24'h00_0000, secl_r};
				end
				`FUPC_A_INFO: begin
					rdata_r <= {19'h0_0000, state_r, usr_ok, rdprot_r, locked_r, opt_r};
				end
				default: begin
					rdata_r <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Unlock key
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			key_r <= 8'h00;
		end else if (wr_acc && avs_address == `FUPC_A_KEY) begin
			key_r <= avs_writedata[7:0];
		end
	end

	// Mode field only accepted with the key in place
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode_r <= 4'h0;
		end else if (wr_acc && avs_address == `FUPC_A_CTRL && usr_ok) begin
			mode_r <= avs_writedata[`FUPC_MODE_HI:`FUPC_MODE_LO];
		end
	end

	// Sector address registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sech_r <= 8'h00;
			secl_r <= 8'h00;
		end else if (wr_acc && avs_address == `FUPC_A_SECH) begin
			sech_r <= avs_writedata[7:0];
		end else if (wr_acc && avs_address == `FUPC_A_SECL) begin
			secl_r <= avs_writedata[7:0];
		end
	end

	// Option byte caught once after reset release
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			opt_r <= 8'h00;
			opt_ok_r <= 1'b0;
		end else if (!opt_ok_r) begin
			opt_r <= option_bits;
			opt_ok_r <= 1'b1;
		end
	end

	// Reset vector, decoded apart from the region size
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			vec_r <= `FUPC_VEC_NONE;
		end else if (opt_r[`FUPC_OPT_VEC_OFF]) begin
			vec_r <= `FUPC_VEC_NONE;
		end else begin
			unique case (opt_r[6:5])
				2'b00: begin
					vec_r <= `FUPC_VEC_0;
				end
				2'b01: begin
					vec_r <= `FUPC_VEC_1;
				end
				2'b10: begin
					vec_r <= `FUPC_VEC_2;
				end
				2'b11: begin
					vec_r <= `FUPC_VEC_3;
				end
			endcase
		end
	end

	// Read protection, settable from tool mode alone
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdprot_r <= 1'b0;
		end else if (tool_rdprot_set && tool_mode) begin
			rdprot_r <= 1'b1;
		end
	end

	// Byte read through plain load cycles
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fl_read_r <= 1'b0;
			fl_raddr_r <= 16'h0000;
			rd_pend_r <= 1'b0;
			pm_rdata_r <= 8'h00;
			pm_rvalid_r <= 1'b0;
		end else begin
			fl_read_r <= pm_load;
			rd_pend_r <= fl_read_r;
			pm_rvalid_r <= rd_pend_r;
			if (pm_load) begin
				fl_raddr_r <= pm_addr;
			end
			if (rd_pend_r) begin
				pm_rdata_r <= fl_rdata;
			end
		end
	end

	// Refused store flag, one cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pm_refused_r <= 1'b0;
		end else begin
			pm_refused_r <= pm_store && !st_ok;
		end
	end

	// Operation sequencer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r <= fupc_pkg::FUPC_IDLE;
			cnt_r <= '0;
			stat_r <= 1'b0;
			locked_r <= 1'b0;
			busy_r <= 1'b0;
			fl_erase_r <= 1'b0;
			fl_prog_r <= 1'b0;
			fl_lock_r <= 1'b0;
			fl_addr_r <= 16'h0000;
			fl_wdata_r <= 8'h00;
		end else begin
			unique case (state_r)
				fupc_pkg::FUPC_IDLE: begin
					cnt_r <= '0;
					if (start && cmd_w == `FUPC_CMD_ERASE) begin
						if (sec_prot || locked_r) begin
							stat_r <= 1'b1;
						end else begin
							state_r <= fupc_pkg::FUPC_ERASE;
							busy_r <= 1'b1;
							fl_erase_r <= 1'b1;
							fl_addr_r <= sec_base;
						end
					end else if (start && cmd_w == `FUPC_CMD_LOCK) begin
						state_r <= fupc_pkg::FUPC_LOCK;
						busy_r <= 1'b1;
						fl_lock_r <= 1'b1;
					end else if (pm_store && st_ok) begin
						state_r <= fupc_pkg::FUPC_PROG;
						busy_r <= 1'b1;
						fl_prog_r <= 1'b1;
						fl_addr_r <= pm_addr;
						fl_wdata_r <= pm_wdata;
					end
				end
				fupc_pkg::FUPC_ERASE: begin
					cnt_r <= cnt_r + 1'b1;
					if (irq_pending) begin
						state_r <= fupc_pkg::FUPC_IDLE;
						busy_r <= 1'b0;
						fl_erase_r <= 1'b0;
						stat_r <= 1'b1;
					end else if (cnt_r == `FUPC_CNT_W'(ERASE_CYC - 1)) begin
						state_r <= fupc_pkg::FUPC_IDLE;
						busy_r <= 1'b0;
						fl_erase_r <= 1'b0;
						stat_r <= fl_fail;
					end
				end
				fupc_pkg::FUPC_PROG: begin
					cnt_r <= cnt_r + 1'b1;
					if (irq_pending || cnt_r == `FUPC_CNT_W'(PROG_CYC - 1)) begin
						state_r <= fupc_pkg::FUPC_IDLE;
						busy_r <= 1'b0;
						fl_prog_r <= 1'b0;
					end
				end
				fupc_pkg::FUPC_LOCK: begin
					cnt_r <= cnt_r + 1'b1;
					if (irq_pending) begin
						state_r <= fupc_pkg::FUPC_IDLE;
						busy_r <= 1'b0;
						fl_lock_r <= 1'b0;
					end else if (cnt_r == `FUPC_CNT_W'(LOCK_CYC - 1)) begin
						state_r <= fupc_pkg::FUPC_IDLE;
						busy_r <= 1'b0;
						fl_lock_r <= 1'b0;
						locked_r <= 1'b1;
					end
				end
			endcase
		end
	end

	// Outputs
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign pm_rdata = pm_rdata_r;
	assign pm_rvalid = pm_rvalid_r;
	assign pm_refused = pm_refused_r;
	assign pm_busy = busy_r;
	assign reset_vector = vec_r;
	assign read_protect = rdprot_r;
	assign erase_irq_bypass = fl_erase_r;
	assign fl_erase = fl_erase_r;
	assign fl_prog = fl_prog_r;
	assign fl_lock = fl_lock_r;
	assign fl_read = fl_read_r;
	assign fl_addr = fl_addr_r;
	assign fl_raddr = fl_raddr_r;
	assign fl_wdata = fl_wdata_r;

endmodule

// ### fupc_flash_ctrl_monitor.sv
// Port checker of the flash user-programming controller
`timescale 1ns/100ps
module fupc_flash_ctrl_monitor #(
	parameter int ERASE_CYC = 20
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [15:0] pm_addr,
	input wire logic pm_load,
	input wire logic pm_store,
	input wire logic pm_refused,
	input wire logic pm_rvalid,
	input wire logic irq_pending,
	input wire logic subsys_clk,
	input wire logic tool_mode,
	input wire logic [7:0] option_bits,
	input wire logic read_protect,
	input wire logic erase_irq_bypass,
	input wire logic fl_erase,
	input wire logic fl_prog,
	input wire logic fl_read,
	input wire logic [15:0] fl_raddr
);
	logic [19:0] ecnt_r;
	logic [15:0] top_w;
	assign top_w = 16'h0100 + (16'h0100 << option_bits[1:0]);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ecnt_r <= 20'h0;
		end else begin
			ecnt_r <= fl_erase ? ecnt_r + 20'h1 : 20'h0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_len; $fell(fl_erase) && !$past(irq_pending) |-> ecnt_r >= ERASE_CYC; endproperty
	a_len: assert property (p_len) else $error("erase too short");
	property p_abort; fl_erase && irq_pending |=> !fl_erase; endproperty
	a_abort: assert property (p_abort) else $error("erase not aborted");
	property p_byp; $rose(fl_erase) |-> ##[0:1] erase_irq_bypass; endproperty
	a_byp: assert property (p_byp) else $error("no interrupt bypass");
	property p_load; pm_load |=> fl_read && fl_raddr == $past(pm_addr) ##2 pm_rvalid; endproperty
	a_load: assert property (p_load) else $error("load sequence wrong");
	property p_boot;
		pm_store && !tool_mode && !option_bits[2] && pm_addr >= 16'h0100 && pm_addr < top_w
		|=> pm_refused && !fl_prog;
	endproperty
	a_boot: assert property (p_boot) else $error("boot store taken");
	property p_irq; pm_store && irq_pending |=> pm_refused; endproperty
	a_irq: assert property (p_irq) else $error("store taken with irq");
	property p_sub; pm_store && subsys_clk |=> pm_refused; endproperty
	a_sub: assert property (p_sub) else $error("store taken on subclock");
	property p_rdp; $rose(read_protect) |-> $past(tool_mode); endproperty
	a_rdp: assert property (p_rdp) else $error("protect set outside tool mode");
endmodule

// ### fupc_flash_model.sv
// Flash array model: read data and erase outcome
`timescale 1ns/100ps
module fupc_flash_model (
	input wire logic clock,
	input wire logic fl_read,
	input wire logic [15:0] fl_raddr,
	input wire logic fail_req,
	output logic [7:0] fl_rdata,
	output logic fl_fail
);
	// Data follows the read by one cycle, scrambled otherwise
	always_ff @(posedge clock) begin
		fl_rdata <= fl_read ? fl_raddr[7:0] ^ fl_raddr[15:8] : ~fl_rdata;
	end
	assign fl_fail = fail_req;
endmodule

// ### fupc_pkg.sv
// Types of the flash user-programming controller
package fupc_pkg;
	typedef enum logic [1:0] {
		FUPC_IDLE = 2'b00,
		FUPC_ERASE = 2'b01,
		FUPC_PROG = 2'b10,
		FUPC_LOCK = 2'b11
	} fupc_state_t;
endpackage

// ### test_fupc_flash_ctrl.sv
// Bench of the flash user-programming controller
`timescale 1ns/100ps
module test_fupc_flash_ctrl;
	logic clock, resetn, avs_read, avs_write, avs_waitrequest, pm_load, pm_store, pm_rvalid;
	logic pm_refused, pm_busy, irq_pending, subsys_clk, tool_mode, tool_rdprot_set, fail_req;
	logic read_protect, erase_irq_bypass, fl_erase, fl_prog, fl_lock, fl_read, fl_fail;
	logic [4:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] pm_addr, reset_vector, fl_addr, fl_raddr;
	logic [7:0] pm_wdata, pm_rdata, option_bits, fl_wdata, fl_rdata;
	int err_total = 0;
	int checks_done = 0;
	fupc_flash_ctrl #(.ERASE_CYC(20)) dut_u (.clock, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pm_addr, .pm_load,
		.pm_store, .pm_wdata, .pm_rdata, .pm_rvalid, .pm_refused, .pm_busy, .irq_pending,
		.subsys_clk, .tool_mode, .tool_rdprot_set, .option_bits, .reset_vector, .read_protect,
		.erase_irq_bypass, .fl_erase, .fl_prog, .fl_lock, .fl_read, .fl_addr, .fl_raddr,
		.fl_wdata, .fl_rdata, .fl_fail);
	fupc_flash_model flash_u (.clock, .fl_read, .fl_raddr, .fail_req, .fl_rdata, .fl_fail);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] r);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= 4'h1;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clock);
		end
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask
	task automatic pm(input logic st, input logic [15:0] a, input logic [7:0] d);
		pm_addr <= a;
		pm_wdata <= d;
		pm_store <= st;
		pm_load <= !st;
		@(posedge clock);
		pm_store <= 1'b0;
		pm_load <= 1'b0;
		@(posedge clock);
	endtask
	task automatic idle;
		while (pm_busy !== 1'b0) begin
			@(posedge clock);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		$display("[ERR] watchdog expected end seen hang");
		wrap_up;
	end
	initial begin
		{avs_read, avs_write, pm_load, pm_store, irq_pending, subsys_clk} = 6'h00;
		{tool_mode, tool_rdprot_set, fail_req, resetn} = 4'h0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		pm_addr = 16'h0000;
		pm_wdata = 8'h00;
		option_bits = 8'h41;
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		chk("vector", 32'h0500, reset_vector);
		bus(0, 5'h04, 8'h00, q);
		chk("key", 32'h0, q);
		bus(0, 5'h10, 8'h00, q);
		chk("option", 32'h41, q[7:0]);
		bus(0, 5'h14, 8'h00, q);
		chk("unmapped", 32'h0, q);
		bus(1, 5'h00, 8'ha1, q);
		@(posedge clock);
		chk("locked out", 0, fl_erase);
		$display("test reset done");
		bus(1, 5'h04, 8'ha5, q);
		bus(1, 5'h08, 8'h10, q);
		bus(1, 5'h0c, 8'hff, q);
		for (int f = 0; f < 2; f++) begin
			fail_req <= f[0];
			bus(1, 5'h00, 8'ha1, q);
			@(posedge clock);
			chk("erase", 1, fl_erase);
			chk("base", 32'h1080, fl_addr);
			idle;
			bus(0, 5'h00, 8'h00, q);
			chk("status", f, q[3]);
		end
		fail_req <= 1'b0;
		bus(1, 5'h00, 8'ha1, q);
		repeat (4) @(posedge clock);
		irq_pending <= 1'b1;
		@(posedge clock);
		irq_pending <= 1'b0;
		repeat (2) @(posedge clock);
		chk("abort", 0, fl_erase);
		bus(0, 5'h00, 8'h00, q);
		chk("status", 1, q[3]);
		$display("test erase done");
		bus(1, 5'h00, 8'h51, q);
		pm(1, 16'h1084, 8'h78);
		chk("prog", 1, fl_prog);
		chk("wdata", 32'h78, fl_wdata);
		idle;
		pm(0, 16'h1084, 8'h00);
		repeat (3) @(posedge clock);
		chk("load", 32'h94, pm_rdata);
		bus(1, 5'h04, 8'h5a, q);
		pm(1, 16'h1085, 8'h33);
		chk("bad key", 1, pm_refused);
		bus(1, 5'h04, 8'ha5, q);
		$display("test program done");
		for (int i = 0; i < 2; i++) begin
			irq_pending <= (i == 0);
			subsys_clk <= (i == 1);
			pm(1, 16'h1090, 8'h11);
			chk("gated", 1, pm_refused);
		end
		irq_pending <= 1'b0;
		subsys_clk <= 1'b0;
		pm(1, 16'h02f0, 8'h22);
		chk("boot", 1, pm_refused);
		for (int t = 0; t < 2; t++) begin
			tool_mode <= t[0];
			tool_rdprot_set <= 1'b1;
			@(posedge clock);
			tool_rdprot_set <= 1'b0;
			@(posedge clock);
			chk("rdprot", t, read_protect);
		end
		pm(1, 16'h0180, 8'h44);
		chk("tool", 0, pm_refused);
		idle;
		$display("test protect done");
		bus(1, 5'h00, 8'ha1, q);
		idle;
		bus(0, 5'h00, 8'h00, q);
		chk("status clear", 0, q[3]);
		bus(1, 5'h00, 8'h61, q);
		chk("lock", 1, fl_lock);
		idle;
		bus(0, 5'h10, 8'h00, q);
		chk("locked", 1, q[8]);
		bus(1, 5'h00, 8'ha1, q);
		@(posedge clock);
		chk("locked erase", 0, fl_erase);
		bus(0, 5'h00, 8'h00, q);
		chk("locked status", 1, q[3]);
		$display("test lock done");
		wrap_up;
	end
endmodule
bind fupc_flash_ctrl fupc_flash_ctrl_monitor #(.ERASE_CYC(ERASE_CYC)) mon_u (.clock, .resetn,
	.pm_addr, .pm_load, .pm_store, .pm_refused, .pm_rvalid, .irq_pending, .subsys_clk,
	.tool_mode, .option_bits, .read_protect, .erase_irq_bypass, .fl_erase, .fl_prog,
	.fl_read, .fl_raddr);
